// ===== hdl/oss_pkg.sv
// oscillator source select: shared constants and types
// assumes a single 20 MHz system clock and synchronous reset
`default_nettype none

package oss_pkg;

    // ==========================================================
    // group codes
    typedef enum logic [1:0] {
        OSS_GRP_SECONDARY = 2'b00,
        OSS_GRP_FAST_RC   = 2'b01,
        OSS_GRP_SLOW_RC   = 2'b10,
        OSS_GRP_PRIMARY   = 2'b11
    } oss_group_type;

    // ==========================================================
    // primary choice codes
    localparam logic [3:0] OSS_CH_EXT_CLKOUT    = 4'hB;
    localparam logic [3:0] OSS_CH_EXT_IO        = 4'hC;
    localparam logic [3:0] OSS_CH_EXT_PLL4      = 4'hD;
    localparam logic [3:0] OSS_CH_EXT_PLL8      = 4'hE;
    localparam logic [3:0] OSS_CH_EXT_PLL16     = 4'hF;
    localparam logic [3:0] OSS_CH_RC_CLKOUT     = 4'h9;
    localparam logic [3:0] OSS_CH_RC_IO         = 4'h8;
    localparam logic [3:0] OSS_CH_XTAL          = 4'h4;
    localparam logic [3:0] OSS_CH_XTAL_PLL4     = 4'h5;
    localparam logic [3:0] OSS_CH_XTAL_PLL8     = 4'h6;
    localparam logic [3:0] OSS_CH_XTAL_PLL16    = 4'h7;
    localparam logic [2:0] OSS_CH_LOW_XTAL_HI3  = 3'h0;
    localparam logic [2:0] OSS_CH_FAST_XTAL_HI3 = 3'h1;

    // ==========================================================
    // pin function of the crystal output pin
    typedef enum logic [1:0] {
        OSS_PIN_CRYSTAL = 2'b00,
        OSS_PIN_CLKOUT  = 2'b01,
        OSS_PIN_IO      = 2'b10
    } oss_pin_fn_type;

    // pll gain, as a shift: 0 off, 2 x4, 3 x8, 4 x16
    localparam logic [2:0] OSS_PLL_OFF = 3'h0;
    localparam logic [2:0] OSS_PLL_X4  = 3'h2;
    localparam logic [2:0] OSS_PLL_X8  = 3'h3;
    localparam logic [2:0] OSS_PLL_X16 = 3'h4;

    // ==========================================================
    // settle counter and register layout
    localparam int         OSS_SETTLE_BITS   = 10;
    localparam logic [9:0] OSS_SETTLE_LAST   = 10'h3FF;
    localparam int         OSS_CUR_GRP_LSB   = 12;
    localparam int         OSS_TRIM_HI_LSB   = 14;
    localparam int         OSS_TRIM_LO_LSB   = 10;
    localparam int         OSS_LOCK_BIT      = 5;
    localparam logic [15:0] OSS_CTRL_RESET   = 16'h0000;
    // trim step in hundredths of a percent
    localparam int         OSS_TRIM_STEP_CP  = 75;
    // clock output divide: fosc/4
    localparam logic [1:0] OSS_DIV4_LAST     = 2'h3;

endpackage

`default_nettype wire

// ===== hdl/oss_settle_counter.sv
// oscillator source select: crystal settle counter
// assumes clk_sys_in is the oscillator clock being settled
`default_nettype none

module oss_settle_counter
(
    input  wire logic            clk_sys_in,
    input  wire logic            rst_in,
    oss_settle_if.cnt            settle
);

    logic [oss_pkg::OSS_SETTLE_BITS-1:0] count_q;
    logic                                done_q;

    // ==========================================================
    // counting
    // (RULE21) clear on restart
    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in || settle.restart)
        begin
            count_q <= '0;
            done_q  <= 1'b0;
        end
        // (RULE6) 1024 periods, 10 bits
        else if (!settle.needed)
        begin
            done_q <= 1'b1;
        end
        else if (!done_q)
        begin
            if (count_q == oss_pkg::OSS_SETTLE_LAST)
            begin
                done_q <= 1'b1;
            end
            count_q <= count_q + 10'h001;
        end
    end

    assign settle.done = done_q;

    // (RULE6) release after full count
    AST_SETTLE_LEN: assert property (@(posedge clk_sys_in) // (RULE6)
        disable iff (rst_in)
        $rose(done_q) && settle.needed |-> $past(count_q) == 10'h3FF)
        else $error("settle released early");
    // (RULE21) restart clears done
    AST_SETTLE_CLR: assert property (@(posedge clk_sys_in) // (RULE21)
        disable iff (rst_in)
        settle.restart |=> !done_q && count_q == 10'h000)
        else $error("restart did not clear settle");

endmodule

`default_nettype wire

// ===== hdl/oss_settle_if.sv
// oscillator source select: settle counter hand-shake bundle
// assumes both ends sit on the oscillator clock clk_sys_in
`default_nettype none

interface oss_settle_if;
    logic restart;
    logic needed;
    logic done;

    modport ctl (output restart, output needed, input done);
    modport cnt (input restart, input needed, output done);
endinterface

`default_nettype wire

// ===== hdl/oss_top.sv
// oscillator source select: fuse decode, gating and status
// assumes fuses and enables are stable levels; pll lock and restart
// events come from analog macros outside the clock domain
`default_nettype none

// Contract
// (RULE1) choose source from group and choice fuses
// (RULE2) group 11 primary 00 sec 01 fast 10 slow
// (RULE3) primary choice decodes to thirteen modes
// (RULE4) crystal out pin follows primary choice
// (RULE5) crystal in pin never general io
// (RULE6) settle counter ten bits, 1024 periods
// (RULE7) settle on restart, crystal modes only
// (RULE8) keep-on holds secondary crystal running
// (RULE9) secondary clocks device only with keep-on
// (RULE10) pll gains x4 x8 x16
// (RULE11) configurer keeps output at most 120 MHz
// (RULE12) lock status mirrors pll lock
// (RULE13) group 01 runs fast internal rc
// (RULE14) trim split over bits 15:14, 11:10
// (RULE15) trim signed steps of 0.75 percent
// (RULE16) slow rc clocks timers and monitor
// (RULE17) slow rc kept on only when needed
// (RULE18) external rc clock out is fosc/4
// (RULE19) reset loads current and requested group
// (RULE20) switch fuse 1x: fuses alone select
// (RULE21) settle clears on restart, gates clock
module oss_top
(
    input  wire logic        clk_sys_in,
    input  wire logic        rst_in,
    input  wire logic        por_bor_in,
    input  wire logic        sleep_wake_in,
    input  wire logic [1:0]  group_select_cfg_in,
    input  wire logic [3:0]  primary_choice_cfg_in,
    input  wire logic [1:0]  switch_monitor_cfg_in,
    input  wire logic        secondary_osc_keep_on_in,
    input  wire logic        watchdog_en_in,
    input  wire logic        power_up_delay_done_in,
    input  wire logic        pll_lock_in,
    input  wire logic [3:0]  fast_rc_trim_in,
    output logic [15:0]      osc_control_reg_out,
    output logic [1:0]       current_group_out,
    output logic [1:0]       requested_group_out,
    output logic [2:0]       pll_gain_shift_out,
    output logic             pll_lock_out,
    output logic             osc_clock_gate_out,
    output logic             secondary_osc_run_out,
    output logic             secondary_is_clock_out,
    output logic             fast_rc_run_out,
    output logic             slow_rc_run_out,
    output logic             slow_rc_to_timers_out,
    output logic signed [10:0] fast_rc_trim_cpct_out,
    output logic [1:0]       crystal_out_pin_fn_out,
    output logic             crystal_out_pin_o_out,
    output logic             crystal_out_pin_oe_n_out,
    output logic             crystal_in_pin_is_osc_out,
    output logic             clock_monitor_en_out
);

    // ==========================================================
    // input synchronisers
    logic [1:0] lock_s_q;
    logic [1:0] por_s_q;
    logic [1:0] wake_s_q;
    logic [1:0] delay_s_q;
    logic       por_prev_q;
    logic       wake_prev_q;

    // edge history reads only the second stage, never the first
    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            lock_s_q    <= 2'h0;
            por_s_q     <= 2'h0;
            wake_s_q    <= 2'h0;
            delay_s_q   <= 2'h0;
            por_prev_q  <= 1'b0;
            wake_prev_q <= 1'b0;
        end
        else
        begin
            lock_s_q    <= {lock_s_q[0], pll_lock_in};
            por_s_q     <= {por_s_q[0], por_bor_in};
            wake_s_q    <= {wake_s_q[0], sleep_wake_in};
            delay_s_q   <= {delay_s_q[0], power_up_delay_done_in};
            por_prev_q  <= por_s_q[1];
            wake_prev_q <= wake_s_q[1];
        end
    end

    // leaving power-on or brownout: falling edge of the reset level
    logic por_exit, wake_rise, restart;
    assign por_exit  = por_prev_q && !por_s_q[1];
    assign wake_rise = wake_s_q[1] && !wake_prev_q;
    assign restart   = por_exit || wake_rise;

    // ==========================================================
    // decode functions
    function automatic logic [2:0] pll_of(input logic [3:0] c);
        // (RULE10) gain from choice
        unique case (c)
            oss_pkg::OSS_CH_EXT_PLL4,
            oss_pkg::OSS_CH_XTAL_PLL4:  pll_of = oss_pkg::OSS_PLL_X4;
            oss_pkg::OSS_CH_EXT_PLL8,
            oss_pkg::OSS_CH_XTAL_PLL8:  pll_of = oss_pkg::OSS_PLL_X8;
            oss_pkg::OSS_CH_EXT_PLL16,
            oss_pkg::OSS_CH_XTAL_PLL16: pll_of = oss_pkg::OSS_PLL_X16;
            default:                    pll_of = oss_pkg::OSS_PLL_OFF;
        endcase
    endfunction

    function automatic logic [1:0] pin_of(input logic [3:0] c);
        // (RULE3) choice to pin use
        unique case (c)
            oss_pkg::OSS_CH_EXT_CLKOUT,
            oss_pkg::OSS_CH_RC_CLKOUT: pin_of = oss_pkg::OSS_PIN_CLKOUT;
            oss_pkg::OSS_CH_EXT_IO,
            oss_pkg::OSS_CH_EXT_PLL4,
            oss_pkg::OSS_CH_EXT_PLL8,
            oss_pkg::OSS_CH_EXT_PLL16,
            oss_pkg::OSS_CH_RC_IO:     pin_of = oss_pkg::OSS_PIN_IO;
            default:                   pin_of = oss_pkg::OSS_PIN_CRYSTAL;
        endcase
    endfunction

    function automatic logic is_crystal(input logic [3:0] c);
        // crystal, low-range and high-speed; pll variants included
        is_crystal = (c[3:2] == 2'b01)
                  || (c[3:1] == oss_pkg::OSS_CH_LOW_XTAL_HI3)
                  || (c[3:1] == oss_pkg::OSS_CH_FAST_XTAL_HI3);
    endfunction

    // ==========================================================
    // group registers
    logic [1:0] cur_grp_q;
    logic [1:0] req_grp_q;
    logic [3:0] choice_q;

    // (RULE1) decode fuses on reset exit
    // (RULE19) load both groups
    // with switching always disabled in this block, fuses alone steer
    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            cur_grp_q <= 2'h3;
            req_grp_q <= 2'h3;
            choice_q  <= 4'h4;
        end
        else if (por_exit)
        begin
            cur_grp_q <= group_select_cfg_in;
            req_grp_q <= group_select_cfg_in;
            choice_q  <= primary_choice_cfg_in;
        end
    end

    logic primary;
    assign primary = (cur_grp_q == oss_pkg::OSS_GRP_PRIMARY);

    // ==========================================================
    // settle counter
    oss_settle_if settle ();
    logic settle_needed;

    // (RULE7) crystal modes only
    assign settle_needed =
        (cur_grp_q == oss_pkg::OSS_GRP_SECONDARY)
        || (primary && is_crystal(choice_q));
    assign settle.restart = restart;
    assign settle.needed  = settle_needed;

    oss_settle_counter u_settle
    (
        .clk_sys_in (clk_sys_in),
        .rst_in     (rst_in),
        .settle     (settle)
    );

    // ==========================================================
    // source enables and status
    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            osc_clock_gate_out     <= 1'b0;
            pll_gain_shift_out     <= oss_pkg::OSS_PLL_OFF;
            pll_lock_out           <= 1'b0;
            secondary_osc_run_out  <= 1'b0;
            secondary_is_clock_out <= 1'b0;
            fast_rc_run_out        <= 1'b0;
        end
        else
        begin
            // (RULE21) gate until settled
            osc_clock_gate_out <= settle.done && !restart;
            // (RULE2) pll gain ignores choice outside primary
            pll_gain_shift_out <= primary ? pll_of(choice_q)
                                          : oss_pkg::OSS_PLL_OFF;
            // (RULE12) lock mirror
            pll_lock_out <= lock_s_q[1];
            // (RULE8) keep-on runs secondary
            secondary_osc_run_out <= secondary_osc_keep_on_in
                || (cur_grp_q == oss_pkg::OSS_GRP_SECONDARY);
            // (RULE9) secondary as device clock
            secondary_is_clock_out <=
                (cur_grp_q == oss_pkg::OSS_GRP_SECONDARY)
                && secondary_osc_keep_on_in;
            // (RULE13) fast rc on group 01
            fast_rc_run_out <= (cur_grp_q == oss_pkg::OSS_GRP_FAST_RC);
        end
    end

    // ==========================================================
    // slow internal rc keep-alive
    logic monitor_en;
    // (RULE20) 1x disables monitor
    assign monitor_en = !switch_monitor_cfg_in[1];

    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            slow_rc_run_out       <= 1'b1;
            slow_rc_to_timers_out <= 1'b1;
            clock_monitor_en_out  <= 1'b0;
        end
        else
        begin
            clock_monitor_en_out <= monitor_en;
            // (RULE17) on until delay, then conditional
            if (por_s_q[1] || !delay_s_q[1])
            begin
                slow_rc_run_out <= 1'b1;
            end
            else
            begin
                slow_rc_run_out <= monitor_en || watchdog_en_in
                    || (cur_grp_q == oss_pkg::OSS_GRP_SLOW_RC);
            end
            // (RULE16) feeds timers and monitor
            slow_rc_to_timers_out <= slow_rc_run_out;
        end
    end

    // ==========================================================
    // trim and control register image
    // (RULE15) signed 0.75 percent steps, in hundredths
    // 11 bits hold the full -600..+525 span without wrapping
    function automatic logic signed [10:0] trim_cpct(input logic [3:0] t);
        trim_cpct = 11'(signed'(t) * oss_pkg::OSS_TRIM_STEP_CP);
    endfunction

    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            osc_control_reg_out   <= oss_pkg::OSS_CTRL_RESET;
            fast_rc_trim_cpct_out <= 11'h000;
            current_group_out     <= 2'h3;
            requested_group_out   <= 2'h3;
        end
        else
        begin
            fast_rc_trim_cpct_out <= trim_cpct(fast_rc_trim_in);
            current_group_out     <= cur_grp_q;
            requested_group_out   <= req_grp_q;
            osc_control_reg_out   <= 16'h0000;
            // (RULE14) trim split fields
            osc_control_reg_out[oss_pkg::OSS_TRIM_HI_LSB +: 2] <=
                fast_rc_trim_in[3:2];
            osc_control_reg_out[oss_pkg::OSS_TRIM_LO_LSB +: 2] <=
                fast_rc_trim_in[1:0];
            osc_control_reg_out[oss_pkg::OSS_CUR_GRP_LSB +: 2] <=
                cur_grp_q;
            osc_control_reg_out[oss_pkg::OSS_LOCK_BIT] <= lock_s_q[1];
        end
    end

    // ==========================================================
    // crystal pins
    logic [1:0] div_q;

    // (RULE18) fosc/4 divider
    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            div_q <= 2'h0;
        end
        else
        begin
            div_q <= div_q + 2'h1;
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            crystal_out_pin_fn_out    <= oss_pkg::OSS_PIN_CRYSTAL;
            crystal_out_pin_o_out     <= 1'b0;
            crystal_out_pin_oe_n_out  <= 1'b1;
            // (RULE5) crystal in never io
            crystal_in_pin_is_osc_out <= 1'b1;
        end
        else
        begin
            // (RULE4) pin follows choice, any group
            crystal_out_pin_fn_out <= pin_of(choice_q);
            // clock output only; io and crystal leave the pin released
            crystal_out_pin_o_out    <= div_q[1];
            crystal_out_pin_oe_n_out <=
                (pin_of(choice_q) != oss_pkg::OSS_PIN_CLKOUT);
        end
    end

    // ==========================================================
    // checks
    // (RULE19) both groups loaded
    AST_GROUP_LOAD: assert property (@(posedge clk_sys_in) // (RULE19)
        disable iff (rst_in)
        por_exit |=> cur_grp_q == $past(group_select_cfg_in)
                 && req_grp_q == $past(group_select_cfg_in))
        else $error("groups not loaded on reset exit");
    // (RULE9) secondary clock condition
    AST_SEC_CLOCK: assert property (@(posedge clk_sys_in) // (RULE9)
        disable iff (rst_in)
        secondary_is_clock_out |-> $past(cur_grp_q) == 2'b00
                               && $past(secondary_osc_keep_on_in))
        else $error("secondary clock without keep-on");
    // (RULE8) keep-on runs secondary
    AST_SEC_RUN: assert property (@(posedge clk_sys_in) // (RULE8)
        disable iff (rst_in)
        secondary_osc_keep_on_in |=> secondary_osc_run_out)
        else $error("secondary stopped with keep-on");
    // (RULE12) lock rises after synchronised lock rises
    AST_LOCK: assert property (@(posedge clk_sys_in) // (RULE12)
        disable iff (rst_in)
        $rose(lock_s_q[1]) |=> pll_lock_out
            && osc_control_reg_out[5])
        else $error("lock not mirrored");
    // (RULE10) x16 on code 0111
    AST_PLL16: assert property (@(posedge clk_sys_in) // (RULE10)
        disable iff (rst_in)
        primary && choice_q == 4'h7 |=> pll_gain_shift_out == 3'h4)
        else $error("pll gain wrong");
    // (RULE17) slow rc off only when unneeded
    AST_SLOW_RC: assert property (@(posedge clk_sys_in) // (RULE17)
        disable iff (rst_in)
        !slow_rc_run_out |-> $past(delay_s_q[1]) && !$past(watchdog_en_in)
            && $past(switch_monitor_cfg_in[1]))
        else $error("slow rc stopped while needed");
    // (RULE21) no clock for two cycles after restart
    AST_GATE: assert property (@(posedge clk_sys_in) // (RULE21)
        disable iff (rst_in)
        restart && settle_needed |=> !osc_clock_gate_out [*2])
        else $error("clock passed before settling");
    // (RULE5) crystal in stays oscillator
    AST_OSC_IN: assert property (@(posedge clk_sys_in) // (RULE5)
        disable iff (rst_in)
        crystal_in_pin_is_osc_out)
        else $error("crystal in released");

endmodule

`default_nettype wire

// ===== verification/oss_tb.sv
// oscillator source select: self-checking testbench for oss_top
// assumes a 20 MHz clock; fuse, trim and enable inputs are plain levels
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 100ps;

    // ==========================================================
    // stimulus table: group, choice, keep-on, pll shift, pin fn,
    // pin oe_n, settle expected
    typedef struct packed {
        logic [1:0] grp;
        logic [3:0] pc;
        logic       keep;
        logic [2:0] sh;
        logic [1:0] fn;
        logic       oe_n;
        logic       st;
    } oss_row_type;

    // pll rows assume input within range
    localparam oss_row_type ROWS [19] = '{
        '{2'h3, 4'hB, 1'h0, 3'h0, 2'h1, 1'h0, 1'h0},
        '{2'h3, 4'hC, 1'h0, 3'h0, 2'h2, 1'h1, 1'h0},
        '{2'h3, 4'hD, 1'h0, 3'h2, 2'h2, 1'h1, 1'h0},
        '{2'h3, 4'hE, 1'h0, 3'h3, 2'h2, 1'h1, 1'h0},
        '{2'h3, 4'hF, 1'h0, 3'h4, 2'h2, 1'h1, 1'h0},
        '{2'h3, 4'h9, 1'h0, 3'h0, 2'h1, 1'h0, 1'h0},
        '{2'h3, 4'h8, 1'h0, 3'h0, 2'h2, 1'h1, 1'h0},
        '{2'h3, 4'h4, 1'h0, 3'h0, 2'h0, 1'h1, 1'h1},
        '{2'h3, 4'h5, 1'h0, 3'h2, 2'h0, 1'h1, 1'h1},
        '{2'h3, 4'h6, 1'h0, 3'h3, 2'h0, 1'h1, 1'h1},
        '{2'h3, 4'h7, 1'h1, 3'h4, 2'h0, 1'h1, 1'h1},
        '{2'h3, 4'h0, 1'h0, 3'h0, 2'h0, 1'h1, 1'h1},
        '{2'h3, 4'h1, 1'h0, 3'h0, 2'h0, 1'h1, 1'h1},
        '{2'h3, 4'h2, 1'h0, 3'h0, 2'h0, 1'h1, 1'h1},
        '{2'h3, 4'h3, 1'h0, 3'h0, 2'h0, 1'h1, 1'h1},
        '{2'h0, 4'hB, 1'h1, 3'h0, 2'h1, 1'h0, 1'h1},
        '{2'h0, 4'hC, 1'h0, 3'h0, 2'h2, 1'h1, 1'h1},
        '{2'h1, 4'hD, 1'h0, 3'h0, 2'h2, 1'h1, 1'h0},
        '{2'h2, 4'h9, 1'h0, 3'h0, 2'h1, 1'h0, 1'h0}
    };

    logic              clk_sys_in;
    logic              rst_in;
    logic              por_bor_in;
    logic              sleep_wake_in;
    logic [1:0]        group_select_cfg_in;
    logic [3:0]        primary_choice_cfg_in;
    logic [1:0]        switch_monitor_cfg_in;
    logic              secondary_osc_keep_on_in;
    logic              watchdog_en_in;
    logic              power_up_delay_done_in;
    logic              pll_lock_in;
    logic [3:0]        fast_rc_trim_in;
    logic [15:0]       osc_control_reg_out;
    logic [1:0]        current_group_out;
    logic [1:0]        requested_group_out;
    logic [2:0]        pll_gain_shift_out;
    logic              pll_lock_out;
    logic              osc_clock_gate_out;
    logic              secondary_osc_run_out;
    logic              secondary_is_clock_out;
    logic              fast_rc_run_out;
    logic              slow_rc_run_out;
    logic              slow_rc_to_timers_out;
    logic signed [10:0] fast_rc_trim_cpct_out;
    logic [1:0]        crystal_out_pin_fn_out;
    logic              crystal_out_pin_o_out;
    logic              crystal_out_pin_oe_n_out;
    logic              crystal_in_pin_is_osc_out;
    logic              clock_monitor_en_out;
    int                err_total;
    int                cmp_count;
    int                i;

    oss_top dut_u (
        .clk_sys_in, .rst_in, .por_bor_in, .sleep_wake_in,
        .group_select_cfg_in, .primary_choice_cfg_in,
        .switch_monitor_cfg_in, .secondary_osc_keep_on_in,
        .watchdog_en_in, .power_up_delay_done_in, .pll_lock_in,
        .fast_rc_trim_in, .osc_control_reg_out, .current_group_out,
        .requested_group_out, .pll_gain_shift_out, .pll_lock_out,
        .osc_clock_gate_out, .secondary_osc_run_out,
        .secondary_is_clock_out, .fast_rc_run_out, .slow_rc_run_out,
        .slow_rc_to_timers_out, .fast_rc_trim_cpct_out,
        .crystal_out_pin_fn_out, .crystal_out_pin_o_out,
        .crystal_out_pin_oe_n_out, .crystal_in_pin_is_osc_out,
        .clock_monitor_en_out
    );

    // ==========================================================
    // helpers
    initial
    begin
        clk_sys_in = 1'b0;
        forever #25 clk_sys_in = ~clk_sys_in;
    end

    // inputs always move 5 ns after the rising edge
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys_in);
        #5;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic test_done();
        if (err_total == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic exit_por(input logic [1:0] g, input logic [3:0] f,
                            input logic k);
        group_select_cfg_in = g;
        primary_choice_cfg_in = f;
        secondary_osc_keep_on_in = k;
        por_bor_in = 1'b1;
        step(6);
        chk(slow_rc_run_out, 1'b1);
        por_bor_in = 1'b0;
    endtask

    // tolerant window: sync stages before restart detection add a few
    task automatic measure(input logic st);
        int n;
        n = 0;
        while (osc_clock_gate_out !== 1'b0 && n < 12)
        begin
            step(1);
            n++;
        end
        chk(osc_clock_gate_out, 1'b0);
        n = 0;
        while (osc_clock_gate_out !== 1'b1 && n < 1100)
        begin
            step(1);
            n++;
        end
        if (st)
            chk(n >= 1020 && n <= 1034, 1'b1);
        else
            chk(n <= 8, 1'b1);
    endtask

    task automatic div_chk();
        logic [7:0] s;
        int         k;
        for (k = 0; k < 8; k++)
        begin
            s[k] = crystal_out_pin_o_out;
            step(1);
        end
        for (k = 0; k < 6; k++)
            chk(s[k + 2], {~s[k]});
    endtask

    task automatic chk_reset();
        chk(current_group_out, 2'h3);
        chk(osc_control_reg_out, 16'h0000);
        chk(osc_clock_gate_out, 1'b0);
        chk(slow_rc_run_out, 1'b1);
        chk(crystal_out_pin_oe_n_out, 1'b1);
        chk(pll_gain_shift_out, 3'h0);
    endtask

    // ==========================================================
    // main sequence
    initial
    begin
        err_total = 0;
        cmp_count = 0;
        rst_in = 1'b1;
        por_bor_in = 1'b1;
        sleep_wake_in = 1'b0;
        group_select_cfg_in = 2'h3;
        primary_choice_cfg_in = 4'h4;
        switch_monitor_cfg_in = 2'h3;
        secondary_osc_keep_on_in = 1'b0;
        watchdog_en_in = 1'b0;
        power_up_delay_done_in = 1'b1;
        pll_lock_in = 1'b0;
        fast_rc_trim_in = 4'h0;
        step(8);
        chk_reset();
        rst_in = 1'b0;
        step(2);
        foreach (ROWS[r])
        begin
            exit_por(ROWS[r].grp, ROWS[r].pc, ROWS[r].keep);
            measure(ROWS[r].st);
            step(3);
            chk(current_group_out, ROWS[r].grp);
            chk(requested_group_out, ROWS[r].grp);
            chk(osc_control_reg_out[13:12], ROWS[r].grp);
            chk(pll_gain_shift_out, ROWS[r].sh);
            chk(crystal_out_pin_fn_out, ROWS[r].fn);
            chk(crystal_out_pin_oe_n_out, ROWS[r].oe_n);
            chk(crystal_in_pin_is_osc_out, 1'b1);
            chk(secondary_osc_run_out,
                ROWS[r].keep | (ROWS[r].grp == 2'h0));
            chk(secondary_is_clock_out,
                ROWS[r].keep & (ROWS[r].grp == 2'h0));
            chk(fast_rc_run_out, ROWS[r].grp == 2'h1);
            chk(slow_rc_run_out, ROWS[r].grp == 2'h2);
            if (ROWS[r].fn == 2'h1)
                div_chk();
        end
        // fuses are only taken at reset exit
        group_select_cfg_in = 2'h1;
        step(8);
        chk(current_group_out, 2'h2);
        // wake from sleep restarts the settle count
        exit_por(2'h3, 4'h4, 1'b0);
        measure(1'b1);
        sleep_wake_in = 1'b1;
        step(4);
        sleep_wake_in = 1'b0;
        measure(1'b1);
        // lock follows the pll both ways
        pll_lock_in = 1'b1;
        step(6);
        chk(pll_lock_out, 1'b1);
        chk(osc_control_reg_out[5], 1'b1);
        pll_lock_in = 1'b0;
        step(6);
        chk(pll_lock_out, 1'b0);
        chk(osc_control_reg_out[5], 1'b0);
        // every trim code, signed steps
        for (i = 0; i < 16; i++)
        begin
            fast_rc_trim_in = i[3:0];
            step(3);
            chk(osc_control_reg_out[15:14], i[3:2]);
            chk(osc_control_reg_out[11:10], i[1:0]);
            chk(osc_control_reg_out & 16'h03DF, 16'h0000);
            chk(fast_rc_trim_cpct_out,
                16'((i < 8 ? i : i - 16) * 75));
        end
        // slow rc keep-alive sources
        power_up_delay_done_in = 1'b0;
        step(6);
        chk(slow_rc_run_out, 1'b1);
        power_up_delay_done_in = 1'b1;
        step(6);
        chk(slow_rc_run_out, 1'b0);
        watchdog_en_in = 1'b1;
        step(6);
        chk(slow_rc_run_out, 1'b1);
        chk(slow_rc_to_timers_out, 1'b1);
        watchdog_en_in = 1'b0;
        switch_monitor_cfg_in = 2'h1;
        step(6);
        chk(slow_rc_run_out, 1'b1);
        chk(clock_monitor_en_out, 1'b1);
        switch_monitor_cfg_in = 2'h2;
        step(6);
        chk(clock_monitor_en_out, 1'b0);
        chk(slow_rc_to_timers_out, 1'b0);
        // second reset in mid-run
        rst_in = 1'b1;
        step(2);
        chk_reset();
        rst_in = 1'b0;
        step(2);
        chk(current_group_out, 2'h3);
        chk(osc_clock_gate_out, 1'b0);
        test_done();
    end

    // ==========================================================
    // watchdog: about 13k cycles expected, cut at 40k
    initial
    begin
        #(40000 * 50);
        err_total++;
        test_done();
    end
endmodule

`default_nettype wire
